/* inc/itsl_pkg.sv */
// Constants shared by the input timing and sync logic.
// Assumes one converter clock domain plus one data link domain.
package itsl_pkg;
  localparam int ITSL_WORD_W = 16;
  localparam int ITSL_CODE_W = 4;
  localparam int ITSL_PHASE_W = 5;
  localparam int ITSL_RATIO_W = 3;
  localparam int ITSL_CNT_W = 5;
  localparam logic [3:0] ITSL_CODE_MIN = 4'h0;
  localparam logic [3:0] ITSL_CODE_MAX = 4'hf;
  localparam logic [3:0] ITSL_CODE_RST = 4'h0;
  localparam logic [3:0] ITSL_MARGIN_RST = 4'h0;
  localparam logic [4:0] ITSL_PHASE_RST = 5'h00;
  localparam logic [4:0] ITSL_PHASE_ONE = 5'h01;
  localparam logic [4:0] ITSL_CNT_ONE = 5'h01;
  localparam logic [2:0] ITSL_RATIO_MAX = 3'h4;
  localparam logic ITSL_KIND_HOLD = 1'b0;
  localparam logic ITSL_KIND_SETUP = 1'b1;
  // Status bit positions for overwrite
  localparam int ITSL_ST_DATA = 0;
  localparam int ITSL_ST_SYNC = 1;
  typedef enum logic [0:0] {
    ITSL_CHK_IDLE = 1'b0,
    ITSL_CHK_ARMED = 1'b1
  } itsl_chk_e;
endpackage

/* design/itsl_top.sv */
// Input timing margin monitor, output clock delay steering and sync unit.
// Assumes early/real/late taps arrive on link_clk_in; sync pins are async.
`timescale 1ns/100ps
module itsl_top import itsl_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic link_clk_in,
  input wire logic [ITSL_WORD_W-1:0] data_real_in,
  input wire logic [ITSL_WORD_W-1:0] data_early_in,
  input wire logic [ITSL_WORD_W-1:0] data_late_in,
  input wire logic sync_in,
  input wire logic sync_early_in,
  input wire logic sync_late_in,
  input wire logic auto_mode_in,
  input wire logic output_clock_delay_enable_in,
  input wire logic delay_wr_in,
  input wire logic [ITSL_CODE_W-1:0] delay_wdata_in,
  input wire logic [ITSL_CODE_W-1:0] data_margin_in,
  input wire logic [ITSL_CODE_W-1:0] sync_margin_in,
  input wire logic [ITSL_RATIO_W-1:0] sync_ratio_in,
  input wire logic [ITSL_PHASE_W-1:0] clk_phase_in,
  input wire logic data_mask_in,
  input wire logic sync_mask_in,
  input wire logic status_rd_in,
  input wire logic status_wr_in,
  input wire logic [1:0] status_wdata_in,
  output logic [ITSL_CODE_W-1:0] output_clock_delay_code_out,
  output logic [ITSL_CODE_W-1:0] delay_tap_out,
  output logic [ITSL_CODE_W-1:0] data_margin_out,
  output logic [ITSL_CODE_W-1:0] sync_margin_out,
  output logic data_err_flag_out,
  output logic data_err_kind_out,
  output logic sync_err_flag_out,
  output logic irq_n_out,
  output logic irq_oe_out,
  output logic init_pulse_out,
  output logic [ITSL_PHASE_W-1:0] clk_phase_out
);

  function automatic logic [ITSL_CNT_W-1:0] edges_needed(input logic [2:0] r);
    edges_needed = (r > ITSL_RATIO_MAX) ? 5'h00 : (ITSL_CNT_ONE << r);
  endfunction

  function automatic logic [3:0] sat_step(input logic [3:0] c, input logic up);
    if (up) begin
      sat_step = (c == ITSL_CODE_MAX) ? c : c + 4'h1;
    end else begin
      sat_step = (c == ITSL_CODE_MIN) ? c : c - 4'h1;
    end
  endfunction

  // ---- Link domain: margin compare and event handshake
  logic lreq_q, lreq_d, lkind_q, lkind_d;
  logic lack_s1_q, lack_s2_q;
  logic early_bad, late_bad, mism;
  logic cack_q;

  always_comb begin
    early_bad = (data_early_in != data_real_in);
    late_bad = (data_late_in != data_real_in);
    mism = early_bad | late_bad;
    lreq_d = lreq_q;
    lkind_d = lkind_q;
    if (mism && (lreq_q == lack_s2_q)) begin
      lreq_d = ~lreq_q;
      lkind_d = early_bad ? ITSL_KIND_SETUP : ITSL_KIND_HOLD;
    end
  end

  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lreq_q <= 1'b0;
      lkind_q <= ITSL_KIND_HOLD;
      lack_s1_q <= 1'b0;
      lack_s2_q <= 1'b0;
    end else begin
      lreq_q <= lreq_d;
      lkind_q <= lkind_d;
      lack_s1_q <= cack_q;
      lack_s2_q <= lack_s1_q;
    end
  end

  // ---- Core domain: synchronisers
  logic creq_s1_q, creq_s2_q;
  logic sy_s1_q, sy_s2_q, sy_s3_q;
  logic se_s1_q, se_s2_q, sl_s1_q, sl_s2_q;
  logic ev, kind, sy_rise, sy_bad;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      creq_s1_q <= 1'b0;
      creq_s2_q <= 1'b0;
      cack_q <= 1'b0;
      sy_s1_q <= 1'b0;
      sy_s2_q <= 1'b0;
      sy_s3_q <= 1'b0;
      se_s1_q <= 1'b0;
      se_s2_q <= 1'b0;
      sl_s1_q <= 1'b0;
      sl_s2_q <= 1'b0;
    end else begin
      creq_s1_q <= lreq_q;
      creq_s2_q <= creq_s1_q;
      cack_q <= creq_s2_q;
      sy_s1_q <= sync_in;
      sy_s2_q <= sy_s1_q;
      sy_s3_q <= sy_s2_q;
      se_s1_q <= sync_early_in;
      se_s2_q <= se_s1_q;
      sl_s1_q <= sync_late_in;
      sl_s2_q <= sl_s1_q;
    end
  end

  always_comb begin
    ev = creq_s2_q ^ cack_q;
    kind = lkind_q;
    sy_rise = sy_s2_q & ~sy_s3_q;
    sy_bad = sy_rise & ((se_s2_q != sy_s2_q) | (sl_s2_q != sy_s2_q));
  end

  // ---- Core domain: delay code, check state, flags, interrupt
  logic [3:0] code_q, code_d, tap_q, tap_d, dmar_q, dmar_d, smar_q, smar_d;
  itsl_chk_e chk_q, chk_d;
  logic dflag_q, dflag_d, dkind_q, dkind_d, sflag_q, sflag_d;
  logic irq_q, irq_d, dset;

  always_comb begin
    code_d = code_q;
    chk_d = chk_q;
    dmar_d = data_margin_in;
    smar_d = sync_margin_in;
    dset = 1'b0;
    unique case (chk_q)
      ITSL_CHK_IDLE: begin
      end
      ITSL_CHK_ARMED: begin
        if (ev && !auto_mode_in) begin
          dset = 1'b1;
          chk_d = ITSL_CHK_IDLE;
        end
      end
    endcase
    if (auto_mode_in && ev) begin
      dset = 1'b1;
      code_d = sat_step(code_q, kind);
    end
    if (delay_wr_in) begin
      code_d = delay_wdata_in;
    end
    if (data_margin_in != dmar_q || (delay_wr_in && delay_wdata_in != code_q)) begin
      chk_d = ITSL_CHK_ARMED;
    end
    tap_d = output_clock_delay_enable_in ? code_d : ITSL_CODE_MIN;
    dflag_d = dflag_q;
    sflag_d = sflag_q;
    if (status_rd_in) begin
      dflag_d = 1'b0;
      sflag_d = 1'b0;
    end
    if (status_wr_in) begin
      dflag_d = status_wdata_in[ITSL_ST_DATA];
      sflag_d = status_wdata_in[ITSL_ST_SYNC];
    end
    dkind_d = dkind_q;
    if (dset) begin
      dflag_d = 1'b1;
      dkind_d = kind;
    end
    if (sy_bad) begin
      sflag_d = 1'b1;
    end
    irq_d = (dflag_d & ~data_mask_in) | (sflag_d & ~sync_mask_in);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      code_q <= ITSL_CODE_RST;
      tap_q <= ITSL_CODE_MIN;
      dmar_q <= ITSL_MARGIN_RST;
      smar_q <= ITSL_MARGIN_RST;
      chk_q <= ITSL_CHK_ARMED;
      dflag_q <= 1'b0;
      dkind_q <= ITSL_KIND_HOLD;
      sflag_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      code_q <= code_d;
      tap_q <= tap_d;
      dmar_q <= dmar_d;
      smar_q <= smar_d;
      chk_q <= chk_d;
      dflag_q <= dflag_d;
      dkind_q <= dkind_d;
      sflag_q <= sflag_d;
      irq_q <= irq_d;
    end
  end

  // ---- Core domain: sync edge ratio, init pulse, 32-state clock generator
  logic [ITSL_CNT_W-1:0] ecnt_q, ecnt_d, need;
  logic init_q, init_d;
  logic [ITSL_PHASE_W-1:0] ph_q, ph_d;

  always_comb begin
    need = edges_needed(sync_ratio_in);
    ecnt_d = ecnt_q;
    init_d = 1'b0;
    if (need == 5'h00) begin
      ecnt_d = 5'h00;
    end else if (sy_rise) begin
      if (ecnt_q + ITSL_CNT_ONE >= need) begin
        init_d = 1'b1;
        ecnt_d = 5'h00;
      end else begin
        ecnt_d = ecnt_q + ITSL_CNT_ONE;
      end
    end
    // Wraps at 32, so aligned pulses load the next state the count would reach anyway
    ph_d = init_q ? clk_phase_in : ph_q + ITSL_PHASE_ONE;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ecnt_q <= 5'h00;
      init_q <= 1'b0;
      ph_q <= ITSL_PHASE_RST;
    end else begin
      ecnt_q <= ecnt_d;
      init_q <= init_d;
      ph_q <= ph_d;
    end
  end

  always_comb begin
    output_clock_delay_code_out = code_q;
    delay_tap_out = tap_q;
    data_margin_out = dmar_q;
    sync_margin_out = smar_q;
    data_err_flag_out = dflag_q;
    data_err_kind_out = dkind_q;
    sync_err_flag_out = sflag_q;
    irq_n_out = 1'b0;
    irq_oe_out = irq_q;
    init_pulse_out = init_q;
    clk_phase_out = ph_q;
  end

  // ---- Checks
  property p_link_event;
    @(posedge link_clk_in) disable iff (!rst_n_in)
      (mism && lreq_q == lack_s2_q) |=> (lreq_q != $past(lreq_q));
  endproperty
  a_link_event: assert property (p_link_event) else $error("Mismatch not signalled");
  property p_init_one;
    @(posedge clk_in) disable iff (!rst_n_in) init_q |=> !init_q;
  endproperty
  a_init_one: assert property (p_init_one) else $error("Init pulse too wide");
  property p_phase_load;
    @(posedge clk_in) disable iff (!rst_n_in) init_q |=> ph_q == $past(clk_phase_in);
  endproperty
  a_phase_load: assert property (p_phase_load) else $error("Preload not taken");
  property p_phase_count;
    @(posedge clk_in) disable iff (!rst_n_in)
      !init_q |=> ph_q == $past(ph_q) + ITSL_PHASE_ONE;
  endproperty
  a_phase_count: assert property (p_phase_count) else $error("Phase did not advance");
  property p_manual_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
      (!auto_mode_in && !delay_wr_in) |=> $stable(code_q);
  endproperty
  a_manual_hold: assert property (p_manual_hold) else $error("Manual code changed");
  property p_auto_step;
    @(posedge clk_in) disable iff (!rst_n_in)
      (auto_mode_in && ev && !delay_wr_in) |=>
        code_q == sat_step($past(code_q), $past(kind));
  endproperty
  a_auto_step: assert property (p_auto_step) else $error("Auto step wrong");
  property p_sat_top;
    @(posedge clk_in) disable iff (!rst_n_in)
      (auto_mode_in && ev && kind && code_q == ITSL_CODE_MAX && !delay_wr_in)
        |=> code_q == ITSL_CODE_MAX;
  endproperty
  a_sat_top: assert property (p_sat_top) else $error("Delay code wrapped");
  property p_tap_gate;
    @(posedge clk_in) disable iff (!rst_n_in)
      !output_clock_delay_enable_in |=> tap_q == ITSL_CODE_MIN;
  endproperty
  a_tap_gate: assert property (p_tap_gate) else $error("Tap applied while disabled");
  property p_flag_kind;
    @(posedge clk_in) disable iff (!rst_n_in)
      dset |=> dflag_q && dkind_q == $past(kind);
  endproperty
  a_flag_kind: assert property (p_flag_kind) else $error("Flag or kind missed");
  property p_read_clear;
    @(posedge clk_in) disable iff (!rst_n_in)
      (status_rd_in && !status_wr_in && !dset) |=> !dflag_q;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("Read did not clear");
  property p_irq;
    @(posedge clk_in) disable iff (!rst_n_in)
      (sflag_q && !$past(sync_mask_in)) |-> irq_q;
  endproperty
  a_irq: assert property (p_irq) else $error("Unmasked flag without irq");
  property p_bad_ratio;
    @(posedge clk_in) disable iff (!rst_n_in)
      sync_ratio_in > ITSL_RATIO_MAX |=> !init_q;
  endproperty
  a_bad_ratio: assert property (p_bad_ratio) else $error("Pulse on invalid ratio");

  c_init: cover property (@(posedge clk_in) disable iff (!rst_n_in) init_q);
  c_auto_up: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    auto_mode_in && ev && kind);
  c_sync_err: cover property (@(posedge clk_in) disable iff (!rst_n_in) sy_bad);
endmodule

/* tb/itsl_far_model.sv */
// Far-side model: data source on the link clock and sync distributor.
// Assumes the bench commands one bad word through err_mode_in.
`timescale 1ns/100ps
module itsl_far_model (
  input wire logic clk_in,
  input wire logic link_clk_in,
  input wire logic [1:0] err_mode_in,
  input wire logic sync_on_in,
  input wire logic sync_bad_in,
  output logic [15:0] real_out,
  output logic [15:0] early_out,
  output logic [15:0] late_out,
  output logic sync_out,
  output logic sync_early_out,
  output logic sync_late_out
);
  logic [4:0] cnt_q = 5'h00;
  logic used_q = 1'b0;
  logic bad;
  logic [15:0] w;
  initial begin
    {real_out, early_out, late_out} = '0;
    {sync_out, sync_early_out, sync_late_out} = '0;
  end
  // Fresh word each link cycle; one commanded word gets a wrong tap
  always @(posedge link_clk_in) begin
    w = 16'($urandom);
    bad = (err_mode_in != 2'h0) && !used_q;
    used_q <= (err_mode_in != 2'h0);
    real_out <= w;
    early_out <= (bad && err_mode_in == 2'h1) ? ~w : w;
    late_out <= (bad && err_mode_in == 2'h2) ? ~w : w;
  end
  // One rising edge every 32 converter cycles
  always @(posedge clk_in) begin
    cnt_q <= cnt_q + 5'h01;
    sync_out <= sync_on_in && (cnt_q < 5'h04);
    sync_early_out <= sync_on_in && (cnt_q < 5'h04);
    sync_late_out <= sync_on_in && (cnt_q < 5'h04) && !sync_bad_in;
  end
endmodule

/* tb/itsl_top_test.sv */
// Bench for the timing monitor and sync unit, with a reference model.
// Assumes itsl_far_model drives the link data and sync pins.
`timescale 1ns/100ps
module itsl_top_test;
  import itsl_pkg::*;
  logic clk_in = 0, link_clk = 0, rst_n = 0, auto = 0, en = 0, wr = 0;
  logic d_mask = 0, s_mask = 0, rd = 0, swr = 0, sync_on = 0, sync_bad = 0;
  logic [1:0] err_mode = 0, swdata = 0;
  logic [3:0] wdata = 0, d_marg = 0, s_marg = 0, code, tap, dm_o, sm_o;
  logic [2:0] ratio = 0;
  logic [4:0] phase = 0, phase_o;
  logic [15:0] dr, de, dl;
  logic se, sy, sl, dflag, kind, sflag, irq_n, irq_oe, pulse;
  int errors = 0, checks_done = 0, exp_code = 0, n;
  always #5 clk_in = ~clk_in;
  initial begin
    #1.3;
    forever #62.5 link_clk = ~link_clk;
  end
  itsl_top dut (.clk_in(clk_in), .rst_n_in(rst_n), .link_clk_in(link_clk),
    .data_real_in(dr), .data_early_in(de), .data_late_in(dl), .sync_in(sy),
    .sync_early_in(se), .sync_late_in(sl), .auto_mode_in(auto),
    .output_clock_delay_enable_in(en), .delay_wr_in(wr), .delay_wdata_in(wdata),
    .data_margin_in(d_marg), .sync_margin_in(s_marg), .sync_ratio_in(ratio),
    .clk_phase_in(phase), .data_mask_in(d_mask), .sync_mask_in(s_mask),
    .status_rd_in(rd), .status_wr_in(swr), .status_wdata_in(swdata),
    .output_clock_delay_code_out(code), .delay_tap_out(tap), .data_margin_out(dm_o),
    .sync_margin_out(sm_o), .data_err_flag_out(dflag), .data_err_kind_out(kind),
    .sync_err_flag_out(sflag), .irq_n_out(irq_n), .irq_oe_out(irq_oe),
    .init_pulse_out(pulse), .clk_phase_out(phase_o));
  itsl_far_model far (.clk_in(clk_in), .link_clk_in(link_clk), .err_mode_in(err_mode),
    .sync_on_in(sync_on), .sync_bad_in(sync_bad), .real_out(dr), .early_out(de),
    .late_out(dl), .sync_out(sy), .sync_early_out(se), .sync_late_out(sl));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  task automatic put_code(input logic [3:0] c);
    wr <= 1;
    wdata <= c;
    step(1);
    wr <= 0;
    exp_code = c;
    step(3);
    check(code, c);
    check(tap, en ? c : 4'h0);
  endtask
  // Clear flags, send one bad word, then compare with the model
  task automatic send_bad(input logic [1:0] m, input logic hit);
    rd <= 1;
    d_mask <= 1'($urandom);
    step(1);
    rd <= 0;
    // Wait out the previous event's handshake, else the word is dropped
    step(40);
    err_mode <= m;
    n = 0;
    while (dflag !== 1'b1 && n < 80) begin
      step(1);
      n++;
    end
    err_mode <= 0;
    step(3);
    check(dflag, hit);
    if (hit && auto && m == 2'h1 && exp_code < 15) exp_code++;
    if (hit && auto && m == 2'h2 && exp_code > 0) exp_code--;
    if (hit) check(kind, m == 2'h1);
    check(code, 16'(exp_code));
    check(tap, en ? 16'(exp_code) : 16'h0);
    check({irq_n, irq_oe}, {1'b0, hit & ~d_mask});
  endtask
  task automatic pulse_gap(output int k, input logic aligned);
    k = 0;
    do begin
      step(1);
      k++;
    end while (pulse !== 1'b1 && k < 1200);
    if (k < 1200) begin
      if (aligned) check(phase_o, 5'(phase - 5'h01));
      step(1);
      check({pulse, 3'h0, phase_o}, {4'h0, phase});
    end
  endtask
  initial begin
    void'($urandom(32'h374cd796));
    d_marg <= 4'($urandom);
    s_marg <= 4'($urandom);
    step(8);
    repeat (2) @(posedge link_clk);
    step(1);
    rst_n <= 1;
    step(3);
    check({code, tap, irq_oe, irq_n, dflag, sflag, pulse}, 16'h0);
    check({dm_o, sm_o}, {d_marg, s_marg});
    put_code(4'($urandom));
    en <= 1;
    put_code(4'($urandom));
    send_bad(2'h1, 1);
    send_bad(2'h1, 0);
    d_marg <= d_marg + 4'h1;
    step(2);
    check(dm_o, d_marg);
    send_bad(2'h2, 1);
    put_code(4'(exp_code) ^ 4'h1);
    send_bad(2'h1, 1);
    auto <= 1;
    put_code(4'h1);
    repeat (2) send_bad(2'h2, 1);
    put_code(4'he);
    repeat (2) send_bad(2'h1, 1);
    repeat (16) send_bad(2'($urandom_range(2, 1)), 1);
    for (int r = 0; r < 6; r++) begin
      ratio <= 3'(r);
      phase <= 5'($urandom);
      sync_on <= 1;
      pulse_gap(n, 0);
      pulse_gap(n, 1);
      pulse_gap(n, 1);
      check(16'(n), (r < 5) ? 16'((32 << r) - 1) : 16'd1200);
    end
    ratio <= 0;
    d_mask <= 1;
    sync_bad <= 1;
    step(80);
    check(sflag, 1'b1);
    sync_bad <= 0;
    s_marg <= s_marg - 4'h1;
    step(40);
    check(irq_oe, 1'b1);
    check(sm_o, s_marg);
    s_mask <= 1;
    step(3);
    check(irq_oe, 1'b0);
    swr <= 1;
    swdata <= 2'b01;
    step(1);
    swr <= 0;
    step(2);
    check({sflag, dflag}, 2'b01);
    rd <= 1;
    step(1);
    rd <= 0;
    step(2);
    check({sflag, dflag}, 2'b00);
    report_and_stop();
  end
  initial begin
    #300000;
    errors++;
    report_and_stop();
  end
endmodule
